// >>> dv/pst_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none

module pst_regs_checker
  import pst_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [9:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        lock_indicator,
  input wire logic [2:0]  modulator_overflow_flags,
  input wire logic        sweep_active_flag,
  input wire logic [6:0]  sensor_raw_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ar_q;

  // Index of the read in flight
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr[9:2];

  // Read data appears
  sequence s_rd;
    $rose(s_axi_rvalid);
  endsequence

  AST_RD_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
  AST_RSVD_A:
    assert property (s_rd ##0 ar_q == PST_IDX_RSVD_A
      |-> s_axi_rdata == {8'h0, PST_RSVD_A_VAL}) else $error("rsvd a");
  AST_RSVD_B:
    assert property (s_rd ##0 ar_q == PST_IDX_RSVD_B
      |-> s_axi_rdata == 32'h0) else $error("rsvd b");
  AST_STATUS:
    assert property (s_rd ##0 ar_q == PST_IDX_STATUS |-> s_axi_rdata ==
      {26'h0, $past(sweep_active_flag, 2), 1'b0,
      $past(modulator_overflow_flags, 2), $past(lock_indicator, 2)})
      else $error("status");
  AST_THERMO:
    assert property (s_rd ##0 ar_q == PST_IDX_THERMO |-> s_axi_rdata ==
      ($past(sensor_raw_code, 2) > PST_CODE_MAX ? {25'h0, PST_CODE_MAX}
      : {25'h0, $past(sensor_raw_code, 2)})) else $error("thermo");
  AST_UNMAP:
    assert property (s_rd ##0 (ar_q < PST_IDX_CTRL || ar_q > PST_IDX_RSVD_B)
      |-> s_axi_rresp == PST_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read");
  AST_MAP_OK:
    assert property (s_rd ##0 (ar_q >= PST_IDX_CTRL && ar_q <= PST_IDX_RSVD_B)
      |-> s_axi_rresp == PST_RESP_OKAY && s_axi_rdata[31:24] == 8'h0)
      else $error("mapped read");
endmodule : pst_regs_checker

bind pst_regs pst_regs_checker pst_regs_checker_inst (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .lock_indicator, .modulator_overflow_flags,
  .sweep_active_flag, .sensor_raw_code
);
`default_nettype wire

// >>> dv/tb_pst_regs.sv
`timescale 1ns/100ps
`default_nettype none

module tb_pst_regs
  import pst_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, lock_indicator;
  logic        sweep_active_flag, sensor_enable;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [2:0]  modulator_overflow_flags;
  logic [6:0]  sensor_raw_code;
  int          n_mismatch, samples_checked;

  pst_regs pst_regs_inst (
    .aclk                     (aclk),
    .aresetn                  (aresetn),
    .s_axi_awaddr             (s_axi_awaddr),
    .s_axi_awvalid            (s_axi_awvalid),
    .s_axi_awready            (s_axi_awready),
    .s_axi_wdata              (s_axi_wdata),
    .s_axi_wstrb              (s_axi_wstrb),
    .s_axi_wvalid             (s_axi_wvalid),
    .s_axi_wready             (s_axi_wready),
    .s_axi_bresp              (s_axi_bresp),
    .s_axi_bvalid             (s_axi_bvalid),
    .s_axi_bready             (s_axi_bready),
    .s_axi_araddr             (s_axi_araddr),
    .s_axi_arvalid            (s_axi_arvalid),
    .s_axi_arready            (s_axi_arready),
    .s_axi_rdata              (s_axi_rdata),
    .s_axi_rresp              (s_axi_rresp),
    .s_axi_rvalid             (s_axi_rvalid),
    .s_axi_rready             (s_axi_rready),
    .lock_indicator           (lock_indicator),
    .modulator_overflow_flags (modulator_overflow_flags),
    .sweep_active_flag        (sweep_active_flag),
    .sensor_raw_code          (sensor_raw_code),
    .sensor_enable            (sensor_enable)
  );

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic t_defaults;
    logic [31:0] e [5] = '{32'h0, 32'h0, 32'h20, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      rd({PST_IDX_CTRL + 8'(i), 2'h0}, rv, rr);
      chk("reset value", {rv[29:0], rr}, {e[i][29:0], 2'h0});
    end
  endtask : t_defaults

  task automatic t_ctrl;
    wr({PST_IDX_CTRL, 2'h0}, 32'h1, 4'h1, rr);
    chk("ctrl bresp", {30'h0, rr}, {30'h0, PST_RESP_OKAY});
    @(negedge aclk);
    chk("enable", {31'h0, sensor_enable}, 32'h1);
    wr({PST_IDX_CTRL, 2'h0}, 32'h0, 4'h0, rr);
    rd({PST_IDX_CTRL, 2'h0}, rv, rr);
    chk("ctrl", rv, 32'h1);
    wr({PST_IDX_CTRL, 2'h0}, 32'h0, 4'hf, rr);
    @(negedge aclk);
    chk("enable", {31'h0, sensor_enable}, 32'h0);
  endtask : t_ctrl

  task automatic t_status;
    logic [4:0] p [4] = '{5'h1f, 5'h15, 5'h0a, 5'h00};
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      {sweep_active_flag, modulator_overflow_flags, lock_indicator} <= p[i];
      repeat (3) @(posedge aclk);
      rd({PST_IDX_STATUS, 2'h0}, rv, rr);
      chk("status", rv, {26'h0, p[i][4], 1'b0, p[i][3:0]});
    end
  endtask : t_status

  task automatic t_thermo;
    logic [6:0] c [5] = '{7'h00, 7'h06, 7'h07, 7'h08, 7'h7f};
    wr({PST_IDX_CTRL, 2'h0}, 32'h1, 4'h1, rr);
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      sensor_raw_code <= c[i];
      repeat (3) @(posedge aclk);
      rd({PST_IDX_THERMO, 2'h0}, rv, rr);
      chk("thermo", rv, {25'h0, c[i] > 7'h07 ? 7'h07 : c[i]});
    end
    wr({PST_IDX_CTRL, 2'h0}, 32'h0, 4'h1, rr);
  endtask : t_thermo

  task automatic t_ro;
    logic [31:0] e [4] = '{32'h0, 32'h20, 32'h7, 32'h0};
    for (int i = 0; i < 4; i++) begin
      wr({PST_IDX_STATUS + 8'(i), 2'h0}, 32'hffffff, 4'hf, rr);
      rd({PST_IDX_STATUS + 8'(i), 2'h0}, rv, rr);
      chk("ro reg", rv, e[i]);
    end
    chk("enable", {31'h0, sensor_enable}, 32'h0);
  endtask : t_ro

  task automatic t_unmap;
    rd(10'h074, rv, rr);
    chk("unmapped read", {rv[29:0], rr}, {30'h0, PST_RESP_SLVERR});
    wr(10'h08c, 32'h1, 4'hf, rr);
    chk("unmapped write", {30'h0, rr}, {30'h0, PST_RESP_SLVERR});
  endtask : t_unmap

  task automatic t_reset;
    wr({PST_IDX_CTRL, 2'h0}, 32'h1, 4'h1, rr);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("enable after reset", {31'h0, sensor_enable}, 32'h0);
    rd({PST_IDX_CTRL, 2'h0}, rv, rr);
    chk("ctrl after reset", rv, 32'h0);
  endtask : t_reset

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, lock_indicator, sweep_active_flag} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {modulator_overflow_flags, sensor_raw_code} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_ctrl();
    t_status();
    t_thermo();
    t_ro();
    t_reset();
    t_unmap();
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_pst_regs
`default_nettype wire

// >>> src/pst_code_sat.sv
`timescale 1ns/100ps
`default_nettype none

// Clamps the raw sensor code to its top step
module pst_code_sat
  import pst_pkg::*;
(
  input  wire logic [6:0] raw_code,
  output logic      [6:0] sat_code
);

  // Codes above the top step read as the top step
  assign sat_code = (raw_code > PST_CODE_MAX) ? PST_CODE_MAX : raw_code;

endmodule : pst_code_sat

`default_nettype wire

// >>> src/pst_pkg.sv
package pst_pkg;

  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] PST_IDX_CTRL    = 8'h1e;
  localparam logic [7:0] PST_IDX_STATUS  = 8'h1f;
  localparam logic [7:0] PST_IDX_RSVD_A  = 8'h20;
  localparam logic [7:0] PST_IDX_THERMO  = 8'h21;
  localparam logic [7:0] PST_IDX_RSVD_B  = 8'h22;

  // Field positions
  localparam int PST_CTRL_EN_BIT    = 0;
  localparam int PST_LOCK_BIT       = 0;
  localparam int PST_OVF_LSB        = 1;
  localparam int PST_OVF_W          = 3;
  localparam int PST_SWEEP_BIT      = 5;
  localparam int PST_CODE_W         = 7;
  localparam int PST_REG_W          = 24;

  // Reset and fixed values
  localparam logic [23:0] PST_CTRL_RST   = 24'h000000;
  localparam logic [23:0] PST_STATUS_RST = 24'h000000;
  localparam logic [23:0] PST_RSVD_A_VAL = 24'h000020;
  localparam logic [23:0] PST_RSVD_B_VAL = 24'h000000;
  localparam logic [6:0]  PST_CODE_MAX   = 7'h07;

  // AXI responses
  localparam logic [1:0] PST_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PST_RESP_SLVERR = 2'h2;

endpackage : pst_pkg

// >>> src/pst_regs.sv
// Overview of operation
// - Status bit 0 shows loop lock
// - Status bits 3:1 show modulator overflow
// - Status bit 5 set while sweep runs
// - Flags read together at status 0x1F
// - Temperature code in bits 6:0 of 0x21
// - Code saturates at 7, floors at 0
// - Register 0x20 always reads 0x20
// - Register 0x22 always reads zero
// - Sensor enable is bit 0 of 0x1E
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pst_regs
  import pst_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Hardware status inputs
  input  wire logic        lock_indicator,
  input  wire logic [2:0]  modulator_overflow_flags,
  input  wire logic        sweep_active_flag,
  input  wire logic [6:0]  sensor_raw_code,
  // Sensor control output
  output logic             sensor_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        aw_held_q;
  logic [9:0]  aw_addr_q;
  logic        w_held_q;
  logic [23:0] w_data_q;
  logic [2:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [23:0] ctrl_q;
  logic [23:0] status_q;
  logic [6:0]  code_q;
  logic        en_out_q;
  logic        awready_q;
  logic        wready_q;
  logic        arready_q;

  wire logic        aw_fire;
  wire logic        w_fire;
  wire logic        wr_go;
  wire logic        ar_fire;
  wire logic [7:0]  wr_idx;
  wire logic [7:0]  rd_idx;
  wire logic        wr_ctrl;
  wire logic        wr_mapped;
  wire logic        rd_mapped;
  wire logic [23:0] ctrl_d;
  wire logic [23:0] status_d;
  wire logic [6:0]  code_sat;
  wire logic [23:0] rd_word;
  wire logic [23:0] strb_mask;
  wire logic        aw_held_d;
  wire logic [9:0]  aw_addr_d;
  wire logic        w_held_d;
  wire logic [23:0] w_data_d;
  wire logic [2:0]  w_strb_d;
  wire logic        bvalid_d;
  wire logic [1:0]  bresp_d;
  wire logic        awready_d;
  wire logic        wready_d;
  wire logic        en_out_d;
  wire logic        rvalid_d;
  wire logic [31:0] rdata_d;
  wire logic [1:0]  rresp_d;
  wire logic        arready_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  // Each write channel (address and data) is taken once and held until the response
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign wr_go   = aw_held_q & w_held_q & ~bvalid_q;
  assign ar_fire = s_axi_arvalid & s_axi_arready;

  // Outputs come straight from flops
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_arready = arready_q;
  assign sensor_enable = en_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode (byte address is four times the index)

  assign wr_idx    = aw_addr_q[9:2];
  assign rd_idx    = s_axi_araddr[9:2];
  assign wr_ctrl   = (wr_idx == PST_IDX_CTRL);
  assign wr_mapped = (wr_idx >= PST_IDX_CTRL) && (wr_idx <= PST_IDX_RSVD_B);
  assign rd_mapped = (rd_idx >= PST_IDX_CTRL) && (rd_idx <= PST_IDX_RSVD_B);

  // Byte-lane mask for control writes
  assign strb_mask = {{8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Only the control register takes write data; others ignore it
  assign ctrl_d = (wr_go && wr_ctrl)
    ? ((ctrl_q & ~strb_mask) | (w_data_q[23:0] & strb_mask))
    : ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status capture

  // Lock, overflow and sweep flags packed into one word
  assign status_d = {18'h00000,
                     sweep_active_flag,
                     1'b0,
                     modulator_overflow_flags,
                     lock_indicator};

  // Sensor code clamp
  pst_code_sat u_sat (
    .raw_code (sensor_raw_code),
    .sat_code (code_sat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Fixed and live values per index
  assign rd_word =
    (rd_idx == PST_IDX_CTRL)   ? ctrl_q :
    (rd_idx == PST_IDX_STATUS) ? status_q :
    (rd_idx == PST_IDX_RSVD_A) ? PST_RSVD_A_VAL :
    (rd_idx == PST_IDX_THERMO) ? {17'h00000, code_q} :
    (rd_idx == PST_IDX_RSVD_B) ? PST_RSVD_B_VAL :
    24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Write next state

  // Address and data are latched in either order, freed by the write
  assign aw_held_d = wr_go ? 1'b0 : (aw_held_q | aw_fire);
  assign aw_addr_d = aw_fire ? s_axi_awaddr : aw_addr_q;
  assign w_held_d  = wr_go ? 1'b0 : (w_held_q | w_fire);
  assign w_data_d  = w_fire ? s_axi_wdata[23:0] : w_data_q;
  assign w_strb_d  = w_fire ? s_axi_wstrb[2:0] : w_strb_q;

  // Response raised by the write and held until taken
  assign bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
  assign bresp_d  = wr_go ? (wr_mapped ? PST_RESP_OKAY : PST_RESP_SLVERR)
                          : bresp_q;

  // Ready again once nothing is held and no response waits
  assign awready_d = ~aw_held_d & ~bvalid_d;
  assign wready_d  = ~w_held_d & ~bvalid_d;

  // Enable pin follows the stored bit one cycle later
  assign en_out_d = ctrl_q[PST_CTRL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read next state

  // Data captured with the address and held until taken
  assign rvalid_d  = ar_fire | (rvalid_q & ~s_axi_rready);
  assign rdata_d   = ar_fire ? {8'h00, rd_word} : rdata_q;
  assign rresp_d   = ar_fire ? (rd_mapped ? PST_RESP_OKAY : PST_RESP_SLVERR)
                             : rresp_q;
  assign arready_d = ~rvalid_d;

  ////////////////////////////////////////////////////////////////////////////
  // Write side registers

  // Write address held flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
    end
  end

  // Write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 10'h000;
    end else begin
      aw_addr_q <= aw_addr_d;
    end
  end

  // Write data held flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
    end else begin
      w_held_q <= w_held_d;
    end
  end

  // Write data, register width only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_q <= 24'h000000;
    end else begin
      w_data_q <= w_data_d;
    end
  end

  // Byte strobes of the register lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_strb_q <= 3'h0;
    end else begin
      w_strb_q <= w_strb_d;
    end
  end

  // Write response valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
    end else begin
      bvalid_q <= bvalid_d;
    end
  end

  // Write response code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= PST_RESP_OKAY;
    end else begin
      bresp_q <= bresp_d;
    end
  end

  // Write address ready, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
    end else begin
      awready_q <= awready_d;
    end
  end

  // Write data ready, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
    end else begin
      wready_q <= wready_d;
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PST_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Sensor enable output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_out_q <= 1'b0;
    end else begin
      en_out_q <= en_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware state sampling

  // Status flags refresh every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= PST_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Clamped temperature code refresh every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= 7'h00;
    end else begin
      code_q <= code_sat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side registers

  // Read data valid, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // Read data word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Read response code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rresp_q <= PST_RESP_OKAY;
    end else begin
      rresp_q <= rresp_d;
    end
  end

  // Read address ready, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
    end else begin
      arready_q <= arready_d;
    end
  end

endmodule : pst_regs

`default_nettype wire
